// ---- logic/obt_pkg.sv ----
// constants shared by the octal registered bus transceiver
package obt_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;

  localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] PINS_OFS   = 12'h008;

  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_PINS   = 2'h2;
  localparam logic [1:0] REG_NONE   = 2'h3;

  // control register fields
  localparam int CTRL_B_EN    = 0;
  localparam int CTRL_A_EN_N  = 1;
  localparam int CTRL_TO_BSEL = 2;
  localparam int CTRL_TO_ASEL = 3;
  localparam logic [3:0] CTRL_RST = 4'h2;

  // status register fields
  localparam int STAT_A_STORE = 0;
  localparam int STAT_B_STORE = 8;
  localparam int STAT_A_VALID = 16;
  localparam int STAT_B_VALID = 17;
  localparam int STAT_A_OE    = 18;
  localparam int STAT_B_OE    = 19;

  // pins register fields
  localparam int PINS_A = 0;
  localparam int PINS_B = 8;

  localparam logic [DATA_W-1:0] STORE_RST = 8'h00;

endpackage

// ---- logic/obt_cap_if.sv ----
// link between the transceiver core and one storage register
`timescale 1ns/10ps
`default_nettype none
interface obt_cap_if;
  import obt_pkg::*;
  logic              clkLevel;
  logic [DATA_W-1:0] din;
  logic [DATA_W-1:0] q;
  logic              valid;
  logic              rise;
  modport owner (input clkLevel, input din, output q, output valid, output rise);
  modport user  (output clkLevel, output din, input q, input valid, input rise);
endinterface
`default_nettype wire

// ---- logic/obt_sync3.sv ----
// three-stage pin synchroniser, a bit changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module obt_sync3 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per bit: a one-cycle glitch never reaches q
      q    <= (s2_q & s3_q) | (q & (s2_q | s3_q));
    end
  end
endmodule
`default_nettype wire

// ---- logic/obt_capture.sv ----
// one storage register, loaded on the rising edge of its capture clock level
`timescale 1ns/10ps
`default_nettype none
module obt_capture
  import obt_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  obt_cap_if.owner  cap
);
  logic prevLevel_q;

  // capture ignores selects and enables entirely
  assign cap.rise = cap.clkLevel & ~prevLevel_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prevLevel_q <= 1'b0;
    end else begin
      prevLevel_q <= cap.clkLevel;
    end
  end

  // valid low stands for unknown contents until the first capture
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cap.q     <= STORE_RST;
      cap.valid <= 1'b0;
    end else if (cap.rise) begin
      cap.q     <= cap.din;
      cap.valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- logic/obt_transceiver.sv ----
// octal registered bus transceiver with apb control and status
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module obt_transceiver
  import obt_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [DATA_W-1:0] aPortIn,
  output var  logic [DATA_W-1:0] aPortOut,
  output var  logic              aPortOe,
  input  wire logic [DATA_W-1:0] bPortIn,
  output var  logic [DATA_W-1:0] bPortOut,
  output var  logic              bPortOe,
  input  wire logic              aCaptureClock,
  input  wire logic              bCaptureClock
);

  function automatic logic [1:0] decodeReg(input logic [ADDR_W-1:0] addr);
    logic [1:0] idx;
    if (addr == CTRL_OFS) begin
      idx = REG_CTRL;
    end else if (addr == STATUS_OFS) begin
      idx = REG_STATUS;
    end else if (addr == PINS_OFS) begin
      idx = REG_PINS;
    end else begin
      idx = REG_NONE;
    end
    return idx;
  endfunction

  // inverting path: select high takes the stored word, low the live bus
  function automatic logic [DATA_W-1:0] pickData(
    input logic              sel,
    input logic [DATA_W-1:0] stored,
    input logic [DATA_W-1:0] live
  );
    return ~(sel ? stored : live);
  endfunction

  logic              bDrvEn_q;
  logic              aDrvEnN_q;
  logic              toBSel_q;
  logic              toASel_q;
  logic [DATA_W-1:0] aLive;
  logic [DATA_W-1:0] bLive;
  logic [1:0]        clkLevels;
  logic              apbAccess;
  logic              apbDone;
  logic [1:0]        regSel;
  logic [31:0]       readData;

  obt_cap_if aCap ();
  obt_cap_if bCap ();

  // ---------------- pins into the core clock domain
  obt_sync3 #(
    .W (DATA_W)
  ) aSyncU (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (aPortIn),
    .q        (aLive)
  );

  obt_sync3 #(
    .W (DATA_W)
  ) bSyncU (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (bPortIn),
    .q        (bLive)
  );

  // both capture clocks share one synchroniser so equal edges stay aligned
  obt_sync3 #(
    .W (2)
  ) clkSyncU (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({bCaptureClock, aCaptureClock}),
    .q        (clkLevels)
  );

  // ---------------- storage registers
  assign aCap.clkLevel = clkLevels[0];
  assign bCap.clkLevel = clkLevels[1];
  // a driven port is captured from our own drive, not the resynchronised pin,
  // so the stored word matches the driven word without pin latency
  assign aCap.din = aPortOe ? aPortOut : aLive;
  assign bCap.din = bPortOe ? bPortOut : bLive;

  obt_capture aCapU (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .cap      (aCap.owner)
  );

  obt_capture bCapU (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .cap      (bCap.owner)
  );

  // ---------------- apb slave, one wait state on every access
  assign apbAccess = psel & penable;
  assign apbDone   = apbAccess & pready;
  assign regSel    = decodeReg(paddr);

  always_comb begin
    readData = 32'h0000_0000;
    if (regSel == REG_CTRL) begin
      readData[CTRL_B_EN]    = bDrvEn_q;
      readData[CTRL_A_EN_N]  = aDrvEnN_q;
      readData[CTRL_TO_BSEL] = toBSel_q;
      readData[CTRL_TO_ASEL] = toASel_q;
    end else if (regSel == REG_STATUS) begin
      readData[STAT_A_STORE +: DATA_W] = aCap.q;
      readData[STAT_B_STORE +: DATA_W] = bCap.q;
      readData[STAT_A_VALID]           = aCap.valid;
      readData[STAT_B_VALID]           = bCap.valid;
      readData[STAT_A_OE]              = aPortOe;
      readData[STAT_B_OE]              = bPortOe;
    end else if (regSel == REG_PINS) begin
      readData[PINS_A +: DATA_W] = aLive;
      readData[PINS_B +: DATA_W] = bLive;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= apbAccess & ~pready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apbAccess && !pready) begin
      prdata  <= pwrite ? 32'h0000_0000 : readData;
      pslverr <= (regSel == REG_NONE);
    end else begin
      // the answer stands for the pready cycle only, then returns to zero
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // control word; reset leaves both ports floating
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bDrvEn_q  <= CTRL_RST[CTRL_B_EN];
      aDrvEnN_q <= CTRL_RST[CTRL_A_EN_N];
      toBSel_q  <= CTRL_RST[CTRL_TO_BSEL];
      toASel_q  <= CTRL_RST[CTRL_TO_ASEL];
    end else if (apbDone && pwrite && regSel == REG_CTRL) begin
      bDrvEn_q  <= pwdata[CTRL_B_EN];
      aDrvEnN_q <= pwdata[CTRL_A_EN_N];
      toBSel_q  <= pwdata[CTRL_TO_BSEL];
      toASel_q  <= pwdata[CTRL_TO_ASEL];
    end
  end

  // ---------------- port drivers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bPortOe  <= 1'b0;
      bPortOut <= STORE_RST;
    end else begin
      bPortOe  <= bDrvEn_q;
      bPortOut <= pickData(toBSel_q, aCap.q, aLive);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aPortOe  <= 1'b0;
      aPortOut <= STORE_RST;
    end else begin
      aPortOe  <= ~aDrvEnN_q;
      aPortOut <= pickData(toASel_q, bCap.q, bLive);
    end
  end
  // with both live and both enabled the two inverting paths form a loop
  // that holds each bus at its last level; the loop delay is several cycles
  // so outside logic loading both registers must allow for it

  // ---------------- checks
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic bothLive;
  assign bothLive = bDrvEn_q & ~aDrvEnN_q & ~toBSel_q & ~toASel_q;

  chk_b_enable_write: assert property (
    apbDone && pwrite && regSel == REG_CTRL
      |=> ##1 bPortOe == $past(pwdata[CTRL_B_EN], 2)
  ) else $error("port B enable does not follow control write");

  chk_a_enable_write: assert property (
    apbDone && pwrite && regSel == REG_CTRL
      |=> ##1 aPortOe == !$past(pwdata[CTRL_A_EN_N], 2)
  ) else $error("port A enable does not follow control write");

  chk_b_live_data: assert property (
    bDrvEn_q && !toBSel_q |=> bPortOe && bPortOut == ~$past(aLive)
  ) else $error("port B does not carry inverted live A");

  chk_b_stored_data: assert property (
    toBSel_q ##1 toBSel_q |-> bPortOut == ~$past(aCap.q)
  ) else $error("port B does not carry inverted A register");

  chk_a_live_data: assert property (
    !aDrvEnN_q && !toASel_q |=> aPortOe && aPortOut == ~$past(bLive)
  ) else $error("port A does not carry inverted live B");

  chk_a_stored_data: assert property (
    toASel_q |=> aPortOut == ~$past(bCap.q)
  ) else $error("port A does not carry inverted B register");

  chk_both_stored: assert property (
    bDrvEn_q && !aDrvEnN_q && toBSel_q && toASel_q
      |=> aPortOe && bPortOe
          && aPortOut == ~$past(bCap.q) && bPortOut == ~$past(aCap.q)
  ) else $error("stored data not driven on both ports");

  chk_bus_reinforce: assert property (
    (bothLive && $stable(aLive) && $stable(bLive))[*3]
      |-> aPortOe && bPortOe && $stable(aPortOut) && $stable(bPortOut)
  ) else $error("live loop does not hold bus state");

  chk_a_capture: assert property (
    aCap.rise |=> aCap.q == $past(aCap.din) && aCap.valid
  ) else $error("A register missed a capture edge");

  chk_b_hold: assert property (
    !bCap.rise |=> $stable(bCap.q)
  ) else $error("B register changed without a capture edge");

  chk_b_from_drive: assert property (
    bCap.rise && bPortOe |=> bCap.q == $past(bPortOut)
  ) else $error("B register did not take the driven B word");

  chk_a_from_drive: assert property (
    aCap.rise && aPortOe |=> aCap.q == $past(aPortOut)
  ) else $error("A register did not take the driven A word");

  chk_capture_isolated: assert property (
    $rose(clkLevels[1]) |=> bCap.valid && bCap.q == $past(bCap.din)
  ) else $error("B capture skipped while port state differs");

  chk_reset_float: assert property (
    @(posedge core_clk) disable iff (1'b0)
      !rst_n |=> !aPortOe && !bPortOe && !aCap.valid && !bCap.valid
  ) else $error("ports not floating after reset");

  chk_a_hold: assert property (
    !aCap.rise |=> $stable(aCap.q)
  ) else $error("A register changed without a capture edge");

  chk_a_edge_seen: assert property (
    $rose(clkLevels[0]) |=> aCap.valid && aCap.q == $past(aCap.din)
  ) else $error("A capture skipped while port state differs");

  chk_isolation: assert property (
    !bDrvEn_q && aDrvEnN_q |=> !aPortOe && !bPortOe
  ) else $error("a port is driven while both enables isolate");

  chk_select_write: assert property (
    apbDone && pwrite && regSel == REG_CTRL
      |=> toBSel_q == $past(pwdata[CTRL_TO_BSEL]) && toASel_q == $past(pwdata[CTRL_TO_ASEL])
  ) else $error("selects do not follow control write");

  chk_ctrl_hold: assert property (
    !(apbDone && pwrite && regSel == REG_CTRL)
      |=> $stable(bDrvEn_q) && $stable(aDrvEnN_q) && $stable(toBSel_q) && $stable(toASel_q)
  ) else $error("control word changed without a control write");

  chk_status_read: assert property (
    apbDone && !pwrite && regSel == REG_STATUS
      |-> prdata[STAT_A_STORE +: DATA_W] == $past(aCap.q)
          && prdata[STAT_B_STORE +: DATA_W] == $past(bCap.q)
  ) else $error("status read does not show the storage registers");

  // apb answer: one wait state, then it stands for a single cycle
  chk_wait_state: assert property (
    $rose(apbAccess) |-> !pready ##1 pready
  ) else $error("access not answered after one wait state");

  chk_ready_pulse: assert property (
    pready |=> !pready
  ) else $error("ready stands longer than one cycle");

  chk_err_decode: assert property (
    apbDone |-> pslverr == (regSel == REG_NONE)
  ) else $error("error response does not match the address decode");

  chk_idle_quiet: assert property (
    !pready |-> prdata == 32'h0000_0000 && !pslverr
  ) else $error("read data or error outside the answer cycle");

  chk_write_no_data: assert property (
    apbDone && pwrite |-> prdata == 32'h0000_0000
  ) else $error("write answer carries read data");

  chk_a_valid_sticky: assert property (
    aCap.valid |=> aCap.valid
  ) else $error("A register lost its known state");

  chk_b_valid_sticky: assert property (
    bCap.valid |=> bCap.valid
  ) else $error("B register lost its known state");

  cov_both_stored: cover property (
    bPortOe && aPortOe && toBSel_q && toASel_q
  );

  cov_isolated_capture: cover property (
    !aPortOe && !bPortOe && aCap.rise && bCap.rise
  );

  cov_live_loop: cover property (
    bothLive [*4]
  );

  cov_unmapped_access: cover property (
    apbDone && pslverr
  );

  cov_driven_capture: cover property (
    aPortOe && aCap.rise
  );

endmodule
`default_nettype wire

// ---- sim/obt_bus_partner.sv ----
// far-side bus logic: drives or releases the A and B buses
`timescale 1ns/10ps
`default_nettype none
module obt_bus_partner
  import obt_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              aDrv,
  input  wire logic [DATA_W-1:0] aVal,
  input  wire logic              bDrv,
  input  wire logic [DATA_W-1:0] bVal,
  input  wire logic [DATA_W-1:0] aPortOut,
  input  wire logic              aPortOe,
  input  wire logic [DATA_W-1:0] bPortOut,
  input  wire logic              bPortOe,
  output var  logic [DATA_W-1:0] aBus,
  output var  logic [DATA_W-1:0] bBus
);
  logic [DATA_W-1:0] aLast_q = '0;
  logic [DATA_W-1:0] bLast_q = '0;
  // a released bus shows the inverse of its last level so stale data cannot pass
  always_comb begin
    aBus = aPortOe ? aPortOut : (aDrv ? aVal : ~aLast_q);
    bBus = bPortOe ? bPortOut : (bDrv ? bVal : ~bLast_q);
  end
  always_ff @(posedge core_clk) begin
    if (aPortOe || aDrv) aLast_q <= aBus;
    if (bPortOe || bDrv) bLast_q <= bBus;
  end
endmodule
`default_nettype wire

// ---- sim/tb_octal_registered_bus_transceiver.sv ----
// self-checking bench for the octal registered bus transceiver
`timescale 1ns/10ps
`default_nettype none
module tb_octal_registered_bus_transceiver;
  import obt_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [DATA_W-1:0] aPortIn, aPortOut, bPortIn, bPortOut;
  logic              aPortOe, bPortOe;
  logic              aCaptureClock = 1'b0;
  logic              bCaptureClock = 1'b0;
  logic              aD = 1'b0;
  logic              bD = 1'b0;
  logic [DATA_W-1:0] aV = '0;
  logic [DATA_W-1:0] bV = '0;
  logic [DATA_W-1:0] aM, bM, x;
  logic [31:0]       seed = 32'h6cef;
  logic [31:0]       rd;
  logic              er, sel;
  int                err_total = 0;
  int                cmp_count = 0;

  obt_transceiver obt_transceiver_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aPortIn(aPortIn), .aPortOut(aPortOut),
    .aPortOe(aPortOe), .bPortIn(bPortIn), .bPortOut(bPortOut), .bPortOe(bPortOe),
    .aCaptureClock(aCaptureClock), .bCaptureClock(bCaptureClock));
  obt_bus_partner obt_bus_partner_inst (.core_clk(core_clk), .aDrv(aD), .aVal(aV),
    .bDrv(bD), .bVal(bV), .aPortOut(aPortOut), .aPortOe(aPortOe), .bPortOut(bPortOut),
    .bPortOe(bPortOe), .aBus(aPortIn), .bBus(bPortIn));

  always #20 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [7:0] pick(input logic s, input logic [7:0] st, input logic [7:0] lv);
    return s ? ~st : ~lv;
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // holds the request until pready is seen; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] ad, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // long pulses behind a synchroniser; pin data leads the capture edge by five cycles
  task automatic pulse(input logic a, input logic b);
    cyc(5);
    aCaptureClock <= a;
    bCaptureClock <= b;
    cyc(8);
    aCaptureClock <= 1'b0;
    bCaptureClock <= 1'b0;
    cyc(8);
  endtask
  task automatic stat();
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("aReg", rd[7:0], aM);
    chk("bReg", rd[15:8], bM);
  endtask

  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(2);
    chk("oeReset", {6'h0, aPortOe, bPortOe}, 8'h00);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("validReset", {6'h0, rd[17:16]}, 8'h00);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrlReset", rd[7:0], {4'h0, CTRL_RST});
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", {7'h0, er}, 8'h01);
    chk("unmappedRd", rd[7:0], 8'h00);
    apb(1'b1, 12'h0fc, 32'hf);
    chk("unmappedWr", {7'h0, er}, 8'h01);
    apb(1'b1, STATUS_OFS, 32'hf);
    chk("statusWr", {7'h0, er}, 8'h00);
    aD <= 1'b1;
    bD <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      aV <= seed[7:0];
      bV <= seed[15:8];
      aM = seed[7:0];
      if (i != 2) bM = seed[15:8];
      pulse(1'b1, i != 2);
      stat();
      chk("oeIsolate", {6'h0, aPortOe, bPortOe}, 8'h00);
    end
    chk("valid", {6'h0, rd[17:16]}, 8'h03);
    for (int m = 0; m < 4; m++) begin
      seed = xs(seed);
      x = seed[7:0];
      sel = m[0];
      aD <= !m[1];
      bD <= m[1];
      aV <= x;
      bV <= x;
      apb(1'b1, CTRL_OFS, m[1] ? {28'h0, sel, 3'h0} : {28'h0, 1'b0, sel, 2'h3});
      cyc(12);
      chk("oeDir", {6'h0, aPortOe, bPortOe}, m[1] ? 8'h02 : 8'h01);
      if (!m[1]) begin
        chk("bOut", bPortOut, pick(sel, aM, x));
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        aM = x;
        bM = ~x;
      end else begin
        chk("aOut", aPortOut, pick(sel, bM, x));
        pulse(1'b0, 1'b1);
        pulse(1'b1, 1'b0);
        bM = x;
        aM = ~x;
      end
      stat();
    end
    aD <= 1'b0;
    bD <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'hd);
    cyc(12);
    chk("bothA", aPortOut, ~bM);
    chk("bothB", bPortOut, ~aM);
    chk("oeBoth", {6'h0, aPortOe, bPortOe}, 8'h03);
    apb(1'b1, CTRL_OFS, 32'h3);
    seed = xs(seed);
    aV <= seed[7:0];
    aD <= 1'b1;
    cyc(12);
    apb(1'b1, CTRL_OFS, 32'h1);
    cyc(12);
    aD <= 1'b0;
    cyc(12);
    chk("keepA", aPortOut, aV);
    chk("keepB", bPortOut, ~aV);
    apb(1'b0, PINS_OFS, 32'h0);
    chk("pinsA", rd[7:0], aV);
    close_out();
  end

  initial begin
    cyc(20000);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
